// >>> design/goc_pkg.sv
// Contract
// - Gated one-shot counts only when armed
// - Armed gate edge starts one-shot counting
// - One-shot terminal count reloads, stops, awaits gate
// - One-shot stays armed after terminal count
// - Gate ignored while one-shot is counting
// - Double-count mode ignores gate entirely
// - Double-count counts terminal count twice, disarms
// - Counter preloaded by load command or terminal count
// - First terminal count reloads from hold
// - Second terminal count reloads load, disarms
// - Toggle output mode gives delayed pulse
// - Initial value sets delay, hold sets width
package goc_pkg;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_END = 16'h0001;
  localparam int SYNC_STAGES = 3;
  typedef enum logic {GOC_ONESHOT, GOC_DOUBLE} goc_mode_type;
  typedef enum logic [1:0] {GOC_IDLE, GOC_WAIT, GOC_RUN1, GOC_RUN2} goc_state_type;
endpackage

// >>> design/goc_sync.sv
`timescale 1ns/1ps
module goc_sync (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic pin,
  output logic level,
  output logic rise
);
  import goc_pkg::*;
  logic [SYNC_STAGES-1:0] stage_ff;
  logic level_ff;
  logic rise_ff;
  wire agree = (stage_ff[1] == stage_ff[2]);
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stage_ff <= '0;
      level_ff <= 1'b0;
      rise_ff <= 1'b0;
    end else begin
      stage_ff <= {stage_ff[1:0], pin};
      if (agree) level_ff <= stage_ff[2];
      rise_ff <= agree && stage_ff[2] && !level_ff;
    end
  end
  assign level = level_ff;
  assign rise = rise_ff;
endmodule

// >>> design/goc_counter.sv
`timescale 1ns/1ps
module goc_counter (
  input wire logic mclk,
  input wire logic rst_b,
  input wire goc_pkg::goc_mode_type mode,
  input wire logic toggle_on_terminal_count,
  input wire logic [goc_pkg::CNT_W-1:0] load_value,
  input wire logic [goc_pkg::CNT_W-1:0] hold_value,
  input wire logic load_cmd,
  input wire logic arm_cmd,
  input wire logic disarm_cmd,
  input wire logic count_src,
  input wire logic gate,
  output logic armed,
  output logic counting,
  output logic terminal_count,
  output logic out,
  output logic [goc_pkg::CNT_W-1:0] count
);
  import goc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // State decode shared by several places
  function automatic logic is_run(input goc_state_type st);
    is_run = (st == GOC_RUN1) || (st == GOC_RUN2);
  endfunction
  function automatic logic is_armed(input goc_state_type st);
    is_armed = (st != GOC_IDLE);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Pin conditioning, one synchroniser per pin
  localparam int PIN_N = 2;
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_rise;
  logic src_rise;
  logic gate_rise;
  assign pin_raw = {gate, count_src};
  assign src_rise = pin_rise[0];
  assign gate_rise = pin_rise[1];
  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_pin
      goc_sync u_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .pin(pin_raw[gi]),
        .level(),
        .rise(pin_rise[gi])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Registers and their next values
  goc_state_type state_ff;
  goc_state_type nxt_state;
  logic [CNT_W-1:0] count_ff;
  logic [CNT_W-1:0] nxt_count;
  logic tc_ff;
  logic nxt_tc;
  logic out_ff;
  logic nxt_out;
  logic armed_ff;
  logic nxt_armed;
  logic counting_ff;
  logic nxt_counting;

  //////////////////////////////////////////////////////////////////////////////
  // Mode and state decode
  wire mode_oneshot = (mode == GOC_ONESHOT);
  wire mode_double = (mode == GOC_DOUBLE);
  wire in_idle = (state_ff == GOC_IDLE);
  wire in_wait = (state_ff == GOC_WAIT);
  wire in_run1 = (state_ff == GOC_RUN1);
  wire in_run2 = (state_ff == GOC_RUN2);
  wire run = is_run(state_ff);

  //////////////////////////////////////////////////////////////////////////////
  // Counting events
  wire [CNT_W-1:0] one = {{(CNT_W-1){1'b0}}, 1'b1};
  wire [CNT_W-1:0] dec = count_ff - one;
  wire step = run && src_rise;
  wire at_end = (count_ff == CNT_END);
  wire hit_tc = step && at_end;
  wire arm_take = in_idle && arm_cmd;
  wire gate_take = in_wait && gate_rise;
  // Gate edges are not looked at while running
  wire tc_first = hit_tc && in_run1;
  wire tc_second = hit_tc && in_run2;
  wire os_tc = tc_first && mode_oneshot;
  wire dbl_tc1 = tc_first && mode_double;
  wire reload_hold = dbl_tc1;
  wire reload_load = os_tc || tc_second;
  // A reload at terminal count beats a load command
  wire load_take = load_cmd && !hit_tc;
  wire flip = hit_tc && toggle_on_terminal_count;

  //////////////////////////////////////////////////////////////////////////////
  // Count selection
  always_comb begin
    if (reload_hold) begin
      nxt_count = hold_value;
    end else if (reload_load) begin
      nxt_count = load_value;
    end else if (load_take) begin
      nxt_count = load_value;
    end else if (step) begin
      nxt_count = dec;
    end else begin
      nxt_count = count_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencing, disarm wins over everything
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      GOC_IDLE: begin
        if (arm_take && mode_oneshot) begin
          nxt_state = GOC_WAIT;
        end else if (arm_take) begin
          nxt_state = GOC_RUN1;
        end
      end
      GOC_WAIT: begin
        if (gate_take) begin
          nxt_state = GOC_RUN1;
        end
      end
      GOC_RUN1: begin
        if (os_tc) begin
          nxt_state = GOC_WAIT;
        end else if (dbl_tc1) begin
          nxt_state = GOC_RUN2;
        end
      end
      GOC_RUN2: begin
        if (tc_second) begin
          nxt_state = GOC_IDLE;
        end
      end
      default: begin
        nxt_state = GOC_IDLE;
      end
    endcase
    if (disarm_cmd) begin
      nxt_state = GOC_IDLE;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Flag and output next values
  assign nxt_tc = hit_tc;
  assign nxt_out = flip ? !out_ff : out_ff;
  assign nxt_armed = is_armed(nxt_state);
  assign nxt_counting = is_run(nxt_state);

  //////////////////////////////////////////////////////////////////////////////
  // Flops
  // Sequencer state
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= GOC_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Counter value
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      count_ff <= CNT_RST;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // Terminal count pulse
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tc_ff <= 1'b0;
    end else begin
      tc_ff <= nxt_tc;
    end
  end

  // Toggle output
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      out_ff <= 1'b0;
    end else begin
      out_ff <= nxt_out;
    end
  end

  // Armed status
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      armed_ff <= 1'b0;
    end else begin
      armed_ff <= nxt_armed;
    end
  end

  // Counting status
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      counting_ff <= 1'b0;
    end else begin
      counting_ff <= nxt_counting;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops
  assign armed = armed_ff;
  assign counting = counting_ff;
  assign terminal_count = tc_ff;
  assign out = out_ff;
  assign count = count_ff;
endmodule

// >>> sim/goc_checker.sv
`timescale 1ns/1ps
module goc_checker (
  input wire logic mclk,
  input wire logic rst_b,
  input wire goc_pkg::goc_mode_type mode,
  input wire logic arm_cmd,
  input wire logic disarm_cmd,
  input wire logic toggle_on_terminal_count,
  input wire logic [15:0] load_value,
  input wire logic [15:0] hold_value,
  input wire logic armed,
  input wire logic counting,
  input wire logic terminal_count,
  input wire logic out,
  input wire logic [15:0] count
);
  import goc_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_tc_dbl;
    terminal_count && mode == GOC_DOUBLE;
  endsequence
  property p_idle; !armed && !arm_cmd |=> !counting; endproperty
  a_idle: assert property (p_idle) else $error("counting while disarmed");
  property p_os_tc; terminal_count && mode == GOC_ONESHOT |-> armed && !counting && count == load_value; endproperty
  a_os_tc: assert property (p_os_tc) else $error("one-shot end wrong");
  property p_os_run; counting && mode == GOC_ONESHOT && !disarm_cmd |=> counting || terminal_count; endproperty
  a_os_run: assert property (p_os_run) else $error("one-shot stopped early");
  property p_dbl_arm; mode == GOC_DOUBLE && arm_cmd && !armed && !disarm_cmd |=> armed && counting; endproperty
  a_dbl_arm: assert property (p_dbl_arm) else $error("double not started by arm");
  property p_tc1; s_tc_dbl ##0 counting |-> count == hold_value; endproperty
  a_tc1: assert property (p_tc1) else $error("first end not from hold");
  property p_tc2; s_tc_dbl ##0 !counting |-> count == load_value && !armed; endproperty
  a_tc2: assert property (p_tc2) else $error("second end wrong");
  property p_pulse; terminal_count |=> !terminal_count; endproperty
  a_pulse: assert property (p_pulse) else $error("end pulse too long");
  property p_tog; terminal_count && toggle_on_terminal_count |-> out != $past(out); endproperty
  a_tog: assert property (p_tog) else $error("output not toggled");
endmodule
bind goc_counter goc_checker goc_checker_inst (.*);

// >>> sim/goc_partner.sv
`timescale 1ns/1ps
module goc_partner (
  output logic gate,
  output logic count_src
);
  initial {gate, count_src} = 2'h0;
  task automatic src(input int n);
    repeat (n) begin
      #100 count_src <= 1;
      #100 count_src <= 0;
    end
    #200;
  endtask
  task automatic trig;
    #100 gate <= 1;
    #100 gate <= 0;
    #200;
  endtask
endmodule

// >>> sim/goc_counter_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; $display("[ERR] %0t %h %h", $time, a, b); end end
module goc_counter_tb;
  import goc_pkg::*;
  logic mclk, rst_b, toggle_on_terminal_count, load_cmd, arm_cmd, disarm_cmd;
  logic gate, count_src, armed, counting, terminal_count, out;
  goc_mode_type mode;
  logic [15:0] load_value, hold_value, count;
  int err_total, checks;
  goc_counter goc_counter_inst (.*);
  goc_partner goc_partner_inst (.gate, .count_src);
  initial begin
    mclk = 0;
    forever #12.5 mclk = ~mclk;
  end
  task cmd(input int k);
    @(posedge mclk) {load_cmd, arm_cmd, disarm_cmd} <= 3'h4 >> k;
    @(posedge mclk) {load_cmd, arm_cmd, disarm_cmd} <= 3'h0;
    repeat (2) @(posedge mclk);
  endtask
  task t_unarmed;
    cmd(0);
    goc_partner_inst.trig;
    goc_partner_inst.src(2);
    `CHK({counting, count}, {1'b0, 16'h0003})
  endtask
  task t_oneshot;
    cmd(1);
    goc_partner_inst.trig;
    goc_partner_inst.src(1);
    `CHK(count, 16'h0002)
    goc_partner_inst.trig;
    goc_partner_inst.src(2);
    `CHK({armed, counting, count}, {2'h2, 16'h0003})
    goc_partner_inst.trig;
    goc_partner_inst.src(1);
    `CHK(count, 16'h0002)
    goc_partner_inst.src(2);
  endtask
  task t_double;
    cmd(2);
    @(posedge mclk) mode <= GOC_DOUBLE;
    toggle_on_terminal_count <= 1;
    load_value <= 16'h0004;
    hold_value <= 16'h0003;
    cmd(0);
    cmd(1);
    goc_partner_inst.src(4);
    `CHK({count, out}, {16'h0003, 1'b1})
    goc_partner_inst.src(3);
    `CHK({armed, count, out}, {1'b0, 16'h0004, 1'b0})
    goc_partner_inst.trig;
    goc_partner_inst.src(2);
    `CHK(count, 16'h0004)
  endtask
  task test_done;
    $display("errors %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    test_done;
  end
  initial begin
    rst_b = 1'b0;
    {toggle_on_terminal_count, load_cmd, arm_cmd, disarm_cmd} = 4'h0;
    mode = GOC_ONESHOT;
    load_value = 16'h0003;
    hold_value = 16'h0002;
    repeat (10) @(posedge mclk);
    rst_b <= 1;
    t_unarmed;
    t_oneshot;
    t_double;
    test_done;
  end
endmodule
